// file: dtc_defines.svh
// Constants for the dual 8-bit timer control block: offsets, fields, resets, taps.
// Assumes a byte-addressed Avalon-MM slave port with 32-bit data on one core clock.
//
// Operation
// - Each run bit stops and clears its prescaler or up counter at 0 and lets it count up at 1.
// - Bits 4 to 6 of the run control register always read back as one.
// - The second timer pair has a run control register with the same layout and behaviour.
// - Bit 7 of the run control register turns the lower compare double buffer on at 1, off at 0.
// - The mode field picks two 8-bit timers, one 16-bit timer, 8-bit PROGRAMMABLE_PULSE_MODE, or PWM plus timer.
// - PWM period code 00 is reserved and codes 01, 10, 11 give 2^6, 2^7, 2^8 source clocks.
// - Lower clock select picks the external pin, then the 1/2, 1/8 and 1/32 prescaler taps.
// - Outside 16-bit mode upper clock select picks the lower match, then 1/2, 1/32, 1/512 taps.
// - In 16-bit mode the upper counter ignores its select and counts lower counter overflows.
// - A lower compare write loads buffer and active register when buffering is off, else buffer.
// - With buffering on the buffer moves to the active register at PWM overflow or PROGRAMMABLE_PULSE_MODE start.
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// ==========================================================================
// Register byte offsets.
`define DTC_ADDR_W        9
`define DTC_OFF_RUN0      9'h100
`define DTC_OFF_MOD0      9'h104
`define DTC_OFF_LREG0     9'h108
`define DTC_OFF_UREG0     9'h10C
`define DTC_OFF_RUN1      9'h110
`define DTC_OFF_MOD1      9'h114
`define DTC_OFF_LREG1     9'h118
`define DTC_OFF_UREG1     9'h11C
`define DTC_OFF_CNT0      9'h120
`define DTC_OFF_CNT1      9'h124

// ==========================================================================
// Field layout and reset values.
`define DTC_RUN_RSVD_ONES 8'h70
`define DTC_RUN_RST       5'h00
`define DTC_MOD_RST       8'h00
`define DTC_TREG_RST      8'h00
`define DTC_CNT_ALL_ONES  8'hFF
`define DTC_PWM_MASK_6    8'h3F
`define DTC_PWM_MASK_7    8'h7F
`define DTC_PWM_MASK_8    8'hFF
`define DTC_PWM_MASK_RSVD 8'h00

// ==========================================================================
// Prescaler taps, given as the number of low prescaler bits that must be all ones.
`define DTC_PSC_W         9
`define DTC_TAP_HALF_W    1
`define DTC_TAP_EIGHTH_W  3
`define DTC_TAP_32ND_W    5
`define DTC_TAP_512TH_W   9

`endif

// file: dtc_pkg.sv
// Types shared by the dual 8-bit timer control block.
// Assumes dtc_defines.svh supplies the numeric constants.
package dtc_pkg;

  // ========================================================================
  // Operating mode of a timer pair.
  typedef enum logic [1:0] {
    DTC_MODE_TIMER8  = 2'h0,
    DTC_MODE_TIMER16 = 2'h1,
    DTC_MODE_PPG     = 2'h2,
    DTC_MODE_PWM     = 2'h3
  } dtc_mode_type;

  // ========================================================================
  // Writable bits of a run control register, bit 7 then bits 3 to 0.
  typedef struct packed {
    logic lower_reg_buffer_enable;
    logic light_standby_state_keep_running;
    logic pair_prescaler_run;
    logic upper_counter_run;
    logic lower_counter_run;
  } dtc_run_type;

  // Mode register, laid out exactly as the eight register bits.
  typedef struct packed {
    dtc_mode_type pair_operating_mode;
    logic [1:0]   pwm_period_select;
    logic [1:0]   upper_clock_select;
    logic [1:0]   lower_clock_select;
  } dtc_mod_type;

endpackage

// file: dtc_timer_ctrl.sv
// Run and mode control for two pairs of 8-bit interval timers with shared prescalers.
// Assumes a synchronous Avalon-MM master and inputs synchronous to i_core_clk.
//
// The implementer's own choice: the Avalon-MM register port.
`include "dtc_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module dtc_timer_ctrl
  import dtc_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  input  wire logic [`DTC_ADDR_W-1:0] i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [31:0]            i_avs_writedata,
  input  wire logic [3:0]             i_avs_byteenable,
  output logic      [31:0]            o_avs_readdata,
  output logic                        o_avs_waitrequest,
  input  wire logic [1:0]             i_external_count_pin,
  input  wire logic                   i_light_standby_state,
  output logic      [1:0]             o_lower_match_pulse,
  output logic      [1:0]             o_upper_match_pulse,
  output logic      [1:0]             o_pwm_period_pulse
);

  // ========================================================================
  // Storage, indexed by pair.
  dtc_run_type                 run_ff  [2];
  dtc_mod_type                 mod_ff  [2];
  logic [`DTC_PSC_W-1:0]       psc_ff  [2];
  logic [7:0]                  lcnt_ff [2];
  logic [7:0]                  ucnt_ff [2];
  logic [7:0]                  lbuf_ff [2];
  logic [7:0]                  lact_ff [2];
  logic [7:0]                  uact_ff [2];
  logic [1:0]                  ext_ff;
  logic                        wait_ff;
  logic [31:0]                 rdata_ff;

  logic [7:0]                  nxt_lcnt [2];
  logic [7:0]                  nxt_ucnt [2];
  logic [1:0]                  lmatch;
  logic [1:0]                  umatch;
  logic [1:0]                  period_end;
  logic [1:0]                  reload;
  logic [1:0]                  halt;
  logic                        wr_acc;
  logic [31:0]                 rd_value;

  // ========================================================================
  // Helpers.

  // True when the low w bits of the prescaler are all ones, one cycle in 2^w.
  function automatic logic tap(input logic [`DTC_PSC_W-1:0] v, input int w);
    logic [`DTC_PSC_W-1:0] m;
    m   = `DTC_PSC_W'((32'h0000_0001 << w) - 32'h0000_0001);
    tap = &(v | ~m);
  endfunction

  // Read image of a run register; reserved bits are forced high.
  function automatic logic [7:0] run_image(input dtc_run_type r);
    run_image = {r.lower_reg_buffer_enable, 3'h0, r.light_standby_state_keep_running,
                 r.pair_prescaler_run, r.upper_counter_run, r.lower_counter_run}
                | `DTC_RUN_RSVD_ONES;
  endfunction

  // ========================================================================
  // Bus handshake: one wait cycle, then a single-cycle low waitrequest.
  // A request is accepted only on the edge that sees waitrequest low.
  assign wr_acc = i_avs_write && !wait_ff && i_avs_byteenable[0];

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_ff <= 1'b1;
    end else if ((i_avs_read || i_avs_write) && wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  // Read data are captured during the wait cycle and held until the next read.
  always_comb begin
    rd_value = 32'h0000_0000;
    case (i_avs_address)
      `DTC_OFF_RUN0:  rd_value = {24'h00_0000, run_image(run_ff[0])};
      `DTC_OFF_RUN1:  rd_value = {24'h00_0000, run_image(run_ff[1])};
      `DTC_OFF_MOD0:  rd_value = {24'h00_0000, mod_ff[0]};
      `DTC_OFF_MOD1:  rd_value = {24'h00_0000, mod_ff[1]};
      `DTC_OFF_LREG0: rd_value = {24'h00_0000, lact_ff[0]};
      `DTC_OFF_LREG1: rd_value = {24'h00_0000, lact_ff[1]};
      `DTC_OFF_UREG0: rd_value = {24'h00_0000, uact_ff[0]};
      `DTC_OFF_UREG1: rd_value = {24'h00_0000, uact_ff[1]};
      `DTC_OFF_CNT0:  rd_value = {16'h0000, ucnt_ff[0], lcnt_ff[0]};
      `DTC_OFF_CNT1:  rd_value = {16'h0000, ucnt_ff[1], lcnt_ff[1]};
      default:        rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_avs_read && wait_ff) begin
      rdata_ff <= rd_value;
    end
  end

  assign o_avs_readdata    = rdata_ff;
  assign o_avs_waitrequest = wait_ff;

  // ========================================================================
  // Run and mode registers; only byte lane 0 carries register bits.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_ff[0] <= `DTC_RUN_RST;
      run_ff[1] <= `DTC_RUN_RST;
      mod_ff[0] <= `DTC_MOD_RST;
      mod_ff[1] <= `DTC_MOD_RST;
    end else if (wr_acc) begin
      case (i_avs_address)
        `DTC_OFF_RUN0: run_ff[0] <= {i_avs_writedata[7], i_avs_writedata[3:0]};
        `DTC_OFF_RUN1: run_ff[1] <= {i_avs_writedata[7], i_avs_writedata[3:0]};
        `DTC_OFF_MOD0: mod_ff[0] <= i_avs_writedata[7:0];
        `DTC_OFF_MOD1: mod_ff[1] <= i_avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Compare registers. A reload takes the old buffer, so a write in the same
  // cycle lands in the buffer and waits for the next period.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int p = 0; p < 2; p++) begin
        lbuf_ff[p] <= `DTC_TREG_RST;
        lact_ff[p] <= `DTC_TREG_RST;
        uact_ff[p] <= `DTC_TREG_RST;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (reload[p]) begin
          lact_ff[p] <= lbuf_ff[p];
        end
      end
      if (wr_acc) begin
        case (i_avs_address)
          `DTC_OFF_LREG0: begin
            lbuf_ff[0] <= i_avs_writedata[7:0];
            if (!run_ff[0].lower_reg_buffer_enable) begin
              lact_ff[0] <= i_avs_writedata[7:0];
            end
          end
          // The second pair buffers its lower compare exactly as the first.
          `DTC_OFF_LREG1: begin
            lbuf_ff[1] <= i_avs_writedata[7:0];
            if (!run_ff[1].lower_reg_buffer_enable) begin
              lact_ff[1] <= i_avs_writedata[7:0];
            end
          end
          `DTC_OFF_UREG0: uact_ff[0] <= i_avs_writedata[7:0];
          `DTC_OFF_UREG1: uact_ff[1] <= i_avs_writedata[7:0];
          default: ;
        endcase
      end
    end
  end

  // ========================================================================
  // Prescalers and the external pin edge detector.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      psc_ff[0] <= '0;
      psc_ff[1] <= '0;
      ext_ff    <= 2'h0;
    end else begin
      ext_ff <= i_external_count_pin;
      for (int p = 0; p < 2; p++) begin
        // Standby only freezes a prescaler; clearing it is left to the stop bit.
        if (!run_ff[p].pair_prescaler_run) begin
          psc_ff[p] <= '0;
        end else if (!halt[p]) begin
          psc_ff[p] <= psc_ff[p] + `DTC_PSC_W'(1);
        end
      end
    end
  end

  // ========================================================================
  // Counting and compare. Ticks are gated by the run bits and by standby.
  always_comb begin
    logic        lt;
    logic        ut;
    logic        lov;
    logic [7:0]  l_inc;
    logic [7:0]  u_inc;
    logic [7:0]  pmask;
    logic [15:0] w_inc;
    // Scratch values start from zero so no path leaves them unassigned.
    lt    = 1'b0;
    ut    = 1'b0;
    lov   = 1'b0;
    l_inc = 8'h00;
    u_inc = 8'h00;
    pmask = 8'h00;
    w_inc = 16'h0000;
    for (int p = 0; p < 2; p++) begin
      halt[p] = i_light_standby_state && !run_ff[p].light_standby_state_keep_running;
      l_inc   = lcnt_ff[p] + 8'h01;
      u_inc   = ucnt_ff[p] + 8'h01;
      w_inc   = {ucnt_ff[p], lcnt_ff[p]} + 16'h0001;
      case (mod_ff[p].lower_clock_select)
        2'h0:    lt = i_external_count_pin[p] && !ext_ff[p];
        2'h1:    lt = tap(psc_ff[p], `DTC_TAP_HALF_W);
        2'h2:    lt = tap(psc_ff[p], `DTC_TAP_EIGHTH_W);
        default: lt = tap(psc_ff[p], `DTC_TAP_32ND_W);
      endcase
      lt = lt && run_ff[p].lower_counter_run && !halt[p];
      case (mod_ff[p].pwm_period_select)
        2'h1:    pmask = `DTC_PWM_MASK_6;
        2'h2:    pmask = `DTC_PWM_MASK_7;
        2'h3:    pmask = `DTC_PWM_MASK_8;
        default: pmask = `DTC_PWM_MASK_RSVD;
      endcase
      lov           = lt && (lcnt_ff[p] == `DTC_CNT_ALL_ONES);
      lmatch[p]     = lt && (l_inc == lact_ff[p]);
      period_end[p] = 1'b0;
      nxt_lcnt[p]   = lt ? l_inc : lcnt_ff[p];
      case (mod_ff[p].pair_operating_mode)
        DTC_MODE_TIMER8: begin
          if (lmatch[p]) nxt_lcnt[p] = 8'h00;
        end
        DTC_MODE_TIMER16: begin
          // The carry out of the lower byte must enter the compare, or the
          // match would land one full upper step late.
          lmatch[p] = lt && (w_inc == {uact_ff[p], lact_ff[p]});
          if (lmatch[p]) nxt_lcnt[p] = 8'h00;
        end
        DTC_MODE_PPG: begin
          period_end[p] = lt && (l_inc == uact_ff[p]);
          if (period_end[p]) nxt_lcnt[p] = 8'h00;
        end
        DTC_MODE_PWM: begin
          // A reserved period code never ends a period, so no reload happens.
          period_end[p] = lt && (pmask != 8'h00) && ((lcnt_ff[p] | ~pmask) == `DTC_CNT_ALL_ONES);
          if (period_end[p]) nxt_lcnt[p] = 8'h00;
        end
        default: ;
      endcase
      if (!run_ff[p].lower_counter_run) nxt_lcnt[p] = 8'h00;
      reload[p] = run_ff[p].lower_reg_buffer_enable && period_end[p];
      if (mod_ff[p].pair_operating_mode == DTC_MODE_TIMER16) begin
        ut = lov;
      end else begin
        case (mod_ff[p].upper_clock_select)
          2'h0:    ut = lmatch[p];
          2'h1:    ut = tap(psc_ff[p], `DTC_TAP_HALF_W);
          2'h2:    ut = tap(psc_ff[p], `DTC_TAP_32ND_W);
          default: ut = tap(psc_ff[p], `DTC_TAP_512TH_W);
        endcase
      end
      ut          = ut && run_ff[p].upper_counter_run && !halt[p];
      umatch[p]   = 1'b0;
      nxt_ucnt[p] = ut ? u_inc : ucnt_ff[p];
      case (mod_ff[p].pair_operating_mode)
        DTC_MODE_TIMER16: begin
          if (lmatch[p]) nxt_ucnt[p] = 8'h00;
        end
        DTC_MODE_PPG: nxt_ucnt[p] = 8'h00; // The upper register sets the period here.
        default: begin
          umatch[p] = ut && (u_inc == uact_ff[p]);
          if (umatch[p]) nxt_ucnt[p] = 8'h00;
        end
      endcase
      if (!run_ff[p].upper_counter_run) nxt_ucnt[p] = 8'h00;
    end
  end

  // Counter state and registered event pulses.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int p = 0; p < 2; p++) begin
        lcnt_ff[p] <= 8'h00;
        ucnt_ff[p] <= 8'h00;
      end
      o_lower_match_pulse <= 2'h0;
      o_upper_match_pulse <= 2'h0;
      o_pwm_period_pulse  <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        lcnt_ff[p] <= nxt_lcnt[p];
        ucnt_ff[p] <= nxt_ucnt[p];
      end
      o_lower_match_pulse <= lmatch;
      o_upper_match_pulse <= umatch;
      o_pwm_period_pulse  <= period_end;
    end
  end

endmodule

`default_nettype wire

// file: dtc_timer_ctrl_assertions.sv
// Checker for the dual timer control block: bus answer, read-back and quiet outputs.
// Assumes it is bound to dtc_timer_ctrl and sees only that module's ports.
`include "dtc_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module dtc_timer_ctrl_checker
  import dtc_pkg::*;
(
  input wire logic                   i_core_clk,
  input wire logic                   i_rst_n,
  input wire logic [`DTC_ADDR_W-1:0] i_avs_address,
  input wire logic                   i_avs_read,
  input wire logic                   i_avs_write,
  input wire logic [31:0]            i_avs_writedata,
  input wire logic [3:0]             i_avs_byteenable,
  input wire logic [31:0]            o_avs_readdata,
  input wire logic                   o_avs_waitrequest,
  input wire logic [1:0]             i_external_count_pin,
  input wire logic                   i_light_standby_state,
  input wire logic [1:0]             o_lower_match_pulse,
  input wire logic [1:0]             o_upper_match_pulse,
  input wire logic [1:0]             o_pwm_period_pulse
);
  // ========================================================================
  // Shadow copies of written registers; only completed lane-0 writes count.
  logic [7:0] run0_ff;
  logic [7:0] run1_ff;
  logic [7:0] mod0_ff;
  logic       wr_done;
  logic       frz0;
  assign wr_done = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign frz0    = i_light_standby_state && !run0_ff[3];

  // Shadows follow the bus so the outputs can be judged against them.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run0_ff <= 8'h00;
      run1_ff <= 8'h00;
      mod0_ff <= 8'h00;
    end else if (wr_done) begin
      case (i_avs_address)
        `DTC_OFF_RUN0: run0_ff <= i_avs_writedata[7:0];
        `DTC_OFF_RUN1: run1_ff <= i_avs_writedata[7:0];
        `DTC_OFF_MOD0: mod0_ff <= i_avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Properties. Pulse checks wait five quiet cycles because a tick already in
  // flight when a unit stops may still surface.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  answer_next_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("request not answered after one wait cycle");
  answer_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("wait request low for more than one cycle");
  answer_cause_a: assert property ($fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write))
    else $error("answer without a request");
  run_read_a: assert property (
    i_avs_read && !o_avs_waitrequest && i_avs_address == `DTC_OFF_RUN0
    |-> o_avs_readdata[7:0] == {run0_ff[7], 3'b111, run0_ff[3:0]})
    else $error("run read-back wrong");
  run2_read_a: assert property (
    i_avs_read && !o_avs_waitrequest && i_avs_address == `DTC_OFF_RUN1
    |-> o_avs_readdata[7:0] == {run1_ff[7], 3'b111, run1_ff[3:0]})
    else $error("run2 read-back wrong");
  mode_read_a: assert property (
    i_avs_read && !o_avs_waitrequest && i_avs_address == `DTC_OFF_MOD0
    |-> o_avs_readdata[7:0] == mod0_ff)
    else $error("mode read-back wrong");
  lower_stop_a: assert property (
    !run0_ff[0] [*5] |-> !o_lower_match_pulse[0] && !o_pwm_period_pulse[0])
    else $error("stopped lower counter produced an event");
  upper_stop_a: assert property (!run0_ff[1] [*5] |-> !o_upper_match_pulse[0])
    else $error("stopped upper counter produced an event");
  second_stop_a: assert property (!run1_ff[0] [*5] |-> !o_lower_match_pulse[1])
    else $error("stopped second lower counter produced an event");
  standby_freeze_a: assert property (frz0 [*5] |-> o_lower_match_pulse[0] == 1'b0
    && o_upper_match_pulse[0] == 1'b0 && o_pwm_period_pulse[0] == 1'b0)
    else $error("pair ran in standby");
  wide_upper_a: assert property ((mod0_ff[7:6] == 2'b01) [*5] |-> !o_upper_match_pulse[0])
    else $error("upper event in wide mode");
  timer_period_a: assert property (!mod0_ff[7] [*5] |-> !o_pwm_period_pulse[0])
    else $error("period event in a timer mode");
  pwm_rsvd_a: assert property ((mod0_ff[7:4] == 4'b1100) [*5] |-> !o_pwm_period_pulse[0])
    else $error("period event with reserved period code");
endmodule

bind dtc_timer_ctrl dtc_timer_ctrl_checker dtc_timer_ctrl_checker_inst (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_external_count_pin(i_external_count_pin),
  .i_light_standby_state(i_light_standby_state), .o_lower_match_pulse(o_lower_match_pulse),
  .o_upper_match_pulse(o_upper_match_pulse), .o_pwm_period_pulse(o_pwm_period_pulse));
`default_nettype wire

// file: dtc_timer_ctrl_tb.sv
// Self-checking bench for the dual timer control block.
// Expects one wait cycle per bus access; drives an external pin rising every six cycles.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk, rst_n, rd, wr, waitreq, standby;
  logic [8:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] be;
  logic [1:0] ext_pin, ext_div, lo_p, up_p, pw_p;
  int bad_count, checks, n;

  dtc_timer_ctrl dtc_timer_ctrl_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_external_count_pin(ext_pin),
    .i_light_standby_state(standby), .o_lower_match_pulse(lo_p), .o_upper_match_pulse(up_p),
    .o_pwm_period_pulse(pw_p));

  // ========================================================================
  // Clock, and an external count source that rises every six cycles.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    ext_div <= (ext_div == 2'd2) ? 2'd0 : ext_div + 2'd1;
    if (ext_div == 2'd2) ext_pin <= ~ext_pin;
  end

  // ========================================================================
  // Compare, bus and measurement helpers.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // The request stands until the edge that sees waitrequest low; a slave that
  // never answers is left to the watchdog.
  task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d);
    int k;
    k = 0;
    addr  <= a;
    wdata <= {24'h00_0000, d};
    rd    <= ~w;
    wr    <= w;
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0);
    chk(32'(k), 32'd2);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [8:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, 32'h0000_0000 | e);
  endtask
  function automatic logic pick(input int k, input int p);
    return (k == 0) ? lo_p[p] : (k == 1) ? up_p[p] : pw_p[p];
  endfunction
  // Cycles between two events; zero when no event shows in 2500 cycles.
  task automatic gap(input int k, input int p);
    int t;
    t = 0;
    n = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pick(k, p) !== 1'b1 && t < 2500);
    if (t < 2500) begin
      do begin
        @(posedge clk);
        n++;
      end while (pick(k, p) !== 1'b1 && n < 2500);
    end
  endtask
  // Stopping first clears the counters so each measurement starts clean.
  task automatic setup(input int p, input logic [7:0] md, lr, ur, rn);
    logic [8:0] b;
    b = 9'h100 + 9'(p * 16);
    bus(1'b1, b, 8'h00);
    bus(1'b1, b + 9'h004, md);
    bus(1'b1, b + 9'h008, lr);
    bus(1'b1, b + 9'h00C, ur);
    bus(1'b1, b, rn);
  endtask

  // ========================================================================
  // Scenarios.
  task automatic t_regs;
    logic [7:0] v[3] = '{8'hFF, 8'h0F, 8'h80};
    rchk(9'h100, 8'h70);
    rchk(9'h104, 8'h00);
    rchk(9'h110, 8'h70);
    rchk(9'h1FC, 8'h00);
    foreach (v[i]) begin
      bus(1'b1, 9'h100, v[i]);
      rchk(9'h100, v[i] | 8'h70);
      bus(1'b1, 9'h110, v[i]);
      rchk(9'h110, v[i] | 8'h70);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 9'h104, 8'(i * 85));
      rchk(9'h104, 8'(i * 85));
    end
    be <= 4'h0;
    bus(1'b1, 9'h104, 8'h12);
    be <= 4'h1;
    rchk(9'h104, 8'hFF);
    $display("register test done");
  endtask
  task automatic t_clocks;
    int lo[4] = '{24, 8, 32, 128};
    int hi[4] = '{16, 4, 64, 1024};
    for (int c = 0; c < 4; c++) begin
      setup(0, 8'(c), 8'h04, 8'h00, 8'h05);
      gap(0, 0);
      chk(32'(n), 32'(lo[c]));
      setup(0, 8'(c * 4 + 1), 8'h04, 8'h02, 8'h07);
      gap(1, 0);
      chk(32'(n), 32'(hi[c]));
    end
    bus(1'b1, 9'h100, 8'h04);
    rchk(9'h120, 8'h00);
    setup(0, 8'h4D, 8'h00, 8'h01, 8'h07);
    gap(0, 0);
    chk(32'(n), 32'd512);
    setup(1, 8'h01, 8'h04, 8'h00, 8'h05);
    gap(0, 1);
    chk(32'(n), 32'd8);
    setup(1, 8'h05, 8'h04, 8'h02, 8'h07);
    gap(1, 1);
    chk(32'(n), 32'd4);
    $display("clock select test done");
  endtask
  task automatic t_pwm;
    for (int c = 3; c >= 0; c--) begin
      setup(0, 8'hC1 | 8'(c * 16), 8'h80, 8'h00, 8'h05);
      gap(2, 0);
      chk(32'(n), (c == 0) ? 32'd0 : 32'd1 << (c + 6));
    end
    setup(0, 8'hD1, 8'h10, 8'h00, 8'h05);
    rchk(9'h108, 8'h10);
    bus(1'b1, 9'h100, 8'h85);
    gap(2, 0);
    bus(1'b1, 9'h108, 8'h20);
    rchk(9'h108, 8'h10);
    gap(2, 0);
    rchk(9'h108, 8'h20);
    // Pulse mode: the upper register sets a 16-cycle period at the 1/2 tap.
    setup(0, 8'h81, 8'h02, 8'h08, 8'h05);
    gap(2, 0);
    chk(32'(n), 32'd16);
    bus(1'b1, 9'h100, 8'h85);
    gap(2, 0);
    bus(1'b1, 9'h108, 8'h03);
    rchk(9'h108, 8'h02);
    gap(2, 0);
    rchk(9'h108, 8'h03);
    $display("pwm test done");
  endtask
  task automatic t_standby;
    setup(0, 8'h01, 8'h04, 8'h00, 8'h05);
    standby <= 1'b1;
    gap(0, 0);
    chk(32'(n), 32'd0);
    bus(1'b1, 9'h100, 8'h0D);
    gap(0, 0);
    chk(32'(n), 32'd8);
    standby <= 1'b0;
    $display("standby test done");
  endtask

  task automatic give_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hang is cut off well beyond the expected run of about 11k cycles.
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end

  initial begin
    rst_n     = 1'b0;
    rd        = 1'b0;
    wr        = 1'b0;
    addr      = 9'h000;
    wdata     = 32'h0000_0000;
    be        = 4'h1;
    standby   = 1'b0;
    ext_pin   = 2'b00;
    ext_div   = 2'b00;
    bad_count = 0;
    checks    = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_clocks();
    t_pwm();
    t_standby();
    give_verdict();
  end
endmodule
`default_nettype wire
